// ==== logic/sdc_defines.svh ====
`ifndef SDC_DEFINES_SVH
`define SDC_DEFINES_SVH

// Register byte offsets
`define SDC_OFF_DESC_LO 8'h00
`define SDC_OFF_DESC_HI 8'h04
`define SDC_OFF_OFFSET  8'h08
`define SDC_OFF_CTRL    8'h0c
`define SDC_OFF_STATUS  8'h10
`define SDC_OFF_CPL     8'h14
`define SDC_OFF_BASE    8'h18
`define SDC_OFF_LIMIT   8'h1c

// Upper descriptor word fields
`define SDC_HI_ACCESSED 8
`define SDC_HI_TYPE_LSB 8
`define SDC_HI_TYPE_MSB 11
`define SDC_HI_USER     12
`define SDC_HI_DPL_LSB  13
`define SDC_HI_DPL_MSB  14
`define SDC_HI_PRESENT  15
`define SDC_HI_SPARE    20
`define SDC_HI_DSIZE    22
`define SDC_HI_GRAN     23

// Type field bits inside the 4-bit type
`define SDC_TY_CODE     3
`define SDC_TY_CONF     2
`define SDC_TY_READ     1

// Control register fields
`define SDC_CTRL_OP_LSB 0
`define SDC_CTRL_SZ_LSB 2
`define SDC_CTRL_GATE   5
`define SDC_CTRL_OPOVR  6
`define SDC_CTRL_ADOVR  7

// Expand-down upper bounds and granule fill
`define SDC_UB_16       32'h0000ffff
`define SDC_UB_32       32'hffffffff
`define SDC_GRAN_FILL   12'hfff

// Reset values
`define SDC_RST_WORD    32'h00000000
`define SDC_RST_CPL     2'h0

`endif

// ==== logic/sdc_pkg.sv ====
`default_nettype none
package sdc_pkg;
    typedef enum logic [1:0] {
        SDC_OP_READ  = 2'b00,
        SDC_OP_WRITE = 2'b01,
        SDC_OP_LOAD  = 2'b10,
        SDC_OP_XFER  = 2'b11
    } sdc_op_e;

    typedef enum logic {
        SDC_ST_IDLE = 1'b0,
        SDC_ST_EVAL = 1'b1
    } sdc_state_e;
endpackage
`default_nettype wire

// ==== logic/sdc_decode.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"

module sdc_decode (
    input  wire logic [31:0] i_lo,
    input  wire logic [31:0] i_hi,
    output logic      [31:0] o_base,
    output logic      [31:0] o_limit,
    output logic      [3:0]  o_type,
    output logic             o_user,
    output logic      [1:0]  o_dpl,
    output logic             o_present,
    output logic             o_dsize,
    output logic             o_is_code
);
    logic [19:0] raw_limit;

    // Limit field and its scaling
    assign raw_limit = {i_hi[19:16], i_lo[15:0]};
    assign o_limit   = i_hi[`SDC_HI_GRAN] ? {raw_limit, `SDC_GRAN_FILL}
                                          : {12'h000, raw_limit};

    // Base and attribute fields
    assign o_base    = {i_hi[31:24], i_hi[7:0], i_lo[15:0]};
    assign o_user    = i_hi[`SDC_HI_USER];
    assign o_type    = i_hi[`SDC_HI_TYPE_MSB:`SDC_HI_TYPE_LSB];
    assign o_dpl     = i_hi[`SDC_HI_DPL_MSB:`SDC_HI_DPL_LSB];
    assign o_present = i_hi[`SDC_HI_PRESENT];
    assign o_dsize   = o_user & i_hi[`SDC_HI_DSIZE];
    assign o_is_code = o_user & o_type[`SDC_TY_CODE];
endmodule // sdc_decode
`default_nettype wire

// ==== logic/sdc_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"

module sdc_checker (
    input  wire logic        i_clk,
    input  wire logic        i_resetn,
    input  wire logic        i_psel,
    input  wire logic        i_penable,
    input  wire logic        i_pwrite,
    input  wire logic [7:0]  i_paddr,
    input  wire logic [31:0] i_pwdata,
    output logic      [31:0] o_prdata,
    output logic             o_pready,
    output logic             o_pslverr,
    output logic             o_general_protection_fault,
    output logic             o_segment_absent_fault,
    output logic             o_done,
    output logic      [1:0]  o_current_privilege_level
);
    import sdc_pkg::*;

    // Software visible state
    logic [31:0] desc_lo_q;
    logic [31:0] desc_hi_q;
    logic [31:0] desc_hi_d;
    logic [31:0] offset_q;
    logic [7:0]  ctrl_q;
    logic [1:0]  cpl_q;
    logic [1:0]  cpl_d;
    logic [31:0] prdata_q;
    logic        gp_q;
    logic        np_q;
    logic        ok_q;
    logic        done_q;
    logic        op32_q;
    logic        ad32_q;
    sdc_state_e  state_q;

    // Decoded descriptor fields
    logic [31:0] base;
    logic [31:0] limit;
    logic [3:0]  seg_type;
    logic        user;
    logic [1:0]  descriptor_privilege_level;
    logic        present;
    logic        dsize;
    logic        is_code;

    sdc_decode u_decode (
        .i_lo      (desc_lo_q),
        .i_hi      (desc_hi_q),
        .o_base    (base),
        .o_limit   (limit),
        .o_type    (seg_type),
        .o_user    (user),
        .o_dpl     (descriptor_privilege_level),
        .o_present (present),
        .o_dsize   (dsize),
        .o_is_code (is_code)
    );

    // Bus decode
    wire        setup     = i_psel & ~i_penable;
    wire        access    = i_psel & i_penable;
    wire        hit_lo    = i_paddr == `SDC_OFF_DESC_LO;
    wire        hit_hi    = i_paddr == `SDC_OFF_DESC_HI;
    wire        hit_off   = i_paddr == `SDC_OFF_OFFSET;
    wire        hit_ctrl  = i_paddr == `SDC_OFF_CTRL;
    wire        hit_stat  = i_paddr == `SDC_OFF_STATUS;
    wire        hit_cpl   = i_paddr == `SDC_OFF_CPL;
    wire        hit_base  = i_paddr == `SDC_OFF_BASE;
    wire        hit_lim   = i_paddr == `SDC_OFF_LIMIT;
    wire        hit_rw    = hit_lo | hit_hi | hit_off | hit_ctrl | hit_cpl;
    wire        hit_any   = hit_rw | hit_stat | hit_base | hit_lim;
    wire        wr        = access & i_pwrite & hit_rw;
    wire        wr_lo     = wr & hit_lo;
    wire        wr_hi     = wr & hit_hi;
    wire        wr_off    = wr & hit_off;
    wire        wr_ctrl   = wr & hit_ctrl;
    wire        wr_cpl    = wr & hit_cpl;

    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~hit_any;

    // Latched request fields
    wire [1:0]  op_raw    = ctrl_q[`SDC_CTRL_OP_LSB +: 2];
    wire [2:0]  size_m1   = ctrl_q[`SDC_CTRL_SZ_LSB +: 3];
    wire        via_gate  = ctrl_q[`SDC_CTRL_GATE];
    wire        is_rd     = op_raw == SDC_OP_READ;
    wire        is_wr     = op_raw == SDC_OP_WRITE;
    wire        is_load   = op_raw == SDC_OP_LOAD;
    wire        is_xfer   = op_raw == SDC_OP_XFER;
    wire        is_data   = user & ~is_code;

    // Reference extent: first and last byte of the access
    wire [32:0] last_byte = {1'b0, offset_q} + {30'h0, size_m1};
    wire        expdown   = is_data & seg_type[`SDC_TY_CONF];
    wire [31:0] upper_bnd = dsize ? `SDC_UB_32 : `SDC_UB_16;
    wire        up_over   = last_byte > {1'b0, limit};
    wire        dn_under  = offset_q <= limit;
    wire        dn_over   = last_byte > {1'b0, upper_bnd};
    wire        lim_fault = expdown ? (dn_under | dn_over) : up_over;

    // Access rights per request kind
    wire        wr_code   = is_wr & is_code;
    wire        wr_ro     = is_wr & is_data & ~seg_type[`SDC_TY_READ];
    wire        rd_exec   = is_rd & is_code & ~seg_type[`SDC_TY_READ];
    wire        data_sys  = (is_rd | is_wr) & ~user;
    wire        data_bad  = wr_code | wr_ro | rd_exec | data_sys | lim_fault;
    wire        more_priv = descriptor_privilege_level < cpl_q;
    wire        conform   = seg_type[`SDC_TY_CONF];
    wire        no_gate   = is_xfer & ~conform & more_priv & ~via_gate;
    wire        cs_bad    = ~is_code | no_gate;
    wire        ref_gp    = (is_rd | is_wr) ? data_bad : cs_bad;
    wire        ref_np    = ~present;
    wire        ref_ok    = ~ref_np & ~ref_gp;
    wire        cs_load   = (is_load | is_xfer) & ref_ok;

    // New privilege level after a successful transfer
    assign cpl_d = (cs_load & is_xfer & ~conform & via_gate) ? descriptor_privilege_level : cpl_q;

    // Upper word update; hardware set of accessed bit wins over a write
    wire        set_acc   = (state_q == SDC_ST_EVAL) & cs_load;
    wire [31:0] hi_wdata  = wr_hi ? i_pwdata : desc_hi_q;
    assign desc_hi_d = set_acc ? (hi_wdata | 32'h00000100) : hi_wdata;

    // Default sizes from the code size bit with prefix override
    wire        op32_d    = dsize ^ ctrl_q[`SDC_CTRL_OPOVR];
    wire        ad32_d    = dsize ^ ctrl_q[`SDC_CTRL_ADOVR];

    // Read data mux
    wire [31:0] status    = {23'h0, state_q == SDC_ST_EVAL, ad32_q, op32_q, cpl_q,
                             ok_q, np_q, gp_q, done_q};
    wire [31:0] rd_mux    = hit_lo   ? desc_lo_q :
                            hit_hi   ? desc_hi_q :
                            hit_off  ? offset_q :
                            hit_ctrl ? {24'h0, ctrl_q} :
                            hit_stat ? status :
                            hit_cpl  ? {30'h0, cpl_q} :
                            hit_base ? base :
                            hit_lim  ? limit : 32'h00000000;

    // Register writes from the bus
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            desc_lo_q <= `SDC_RST_WORD;
            desc_hi_q <= `SDC_RST_WORD;
            offset_q  <= `SDC_RST_WORD;
            ctrl_q    <= 8'h00;
            prdata_q  <= `SDC_RST_WORD;
        end else begin
            if (wr_lo) desc_lo_q <= i_pwdata;
            desc_hi_q <= desc_hi_d;
            if (wr_off) offset_q <= i_pwdata;
            if (wr_ctrl) ctrl_q <= i_pwdata[7:0];
            if (setup & ~i_pwrite) prdata_q <= rd_mux;
        end
    end

    // Check sequencer: a control write starts one evaluation cycle
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            state_q <= SDC_ST_IDLE;
        end else begin
            unique case (state_q)
                SDC_ST_IDLE: if (wr_ctrl) state_q <= SDC_ST_EVAL;
                SDC_ST_EVAL: state_q <= SDC_ST_IDLE;
            endcase
        end
    end

    // Result capture
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            gp_q   <= 1'b0;
            np_q   <= 1'b0;
            ok_q   <= 1'b0;
            done_q <= 1'b0;
            op32_q <= 1'b0;
            ad32_q <= 1'b0;
            cpl_q  <= `SDC_RST_CPL;
        end else begin
            done_q <= state_q == SDC_ST_EVAL;
            if (state_q == SDC_ST_EVAL) begin
                np_q <= ref_np;
                gp_q <= ref_present_gp(ref_np, ref_gp);
                ok_q <= ref_ok;
                cpl_q <= cpl_d;
                if (cs_load) begin
                    op32_q <= op32_d;
                    ad32_q <= ad32_d;
                end
            end else if (wr_cpl) begin
                cpl_q <= i_pwdata[1:0];
            end
        end
    end

    // Absent fault takes priority, so protection is reported only when present
    function automatic logic ref_present_gp(input logic np, input logic gp);
        ref_present_gp = ~np & gp;
    endfunction

    assign o_prdata                   = prdata_q;
    assign o_general_protection_fault = gp_q;
    assign o_segment_absent_fault     = np_q;
    assign o_done                     = done_q;
    assign o_current_privilege_level  = cpl_q;

    // Checks on the evaluation cycle, with the present/spare hold and base mapping checks
    np_fault_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && !present |=> np_q && !gp_q && done_q)
        else $error("absent descriptor not reported");

    limit_gp_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_rd && user && !expdown
        && last_byte > {1'b0, limit} |=> gp_q)
        else $error("reference past limit not faulted");

    expdown_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && expdown && offset_q <= limit |=> gp_q)
        else $error("expand-down offset at or below limit accepted");

    code_write_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_wr && is_code |=> gp_q && !ok_q)
        else $error("write into code segment accepted");

    exec_read_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_rd && is_code && !seg_type[1] |=> gp_q)
        else $error("read of execute-only code accepted");

    accessed_set_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && cs_load |=> desc_hi_q[`SDC_HI_ACCESSED] && ok_q)
        else $error("accessed bit not set on code load");

    present_kept_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !wr_hi |=> $stable(desc_hi_q[`SDC_HI_PRESENT]) && $stable(desc_hi_q[`SDC_HI_SPARE]))
        else $error("hardware changed present or spare bit");

    conform_cpl_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && is_xfer && is_code && conform && present
        |=> cpl_q == $past(cpl_q))
        else $error("conforming transfer changed privilege level");

    gate_only_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_xfer && is_code && !conform
        && descriptor_privilege_level < cpl_q && !via_gate |=> gp_q ##1 !done_q)
        else $error("privileged non-conforming transfer without gate");

    base_map_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        base == {desc_hi_q[31:24], desc_hi_q[7:0], desc_lo_q[15:0]}
        && limit[11:0] == (desc_hi_q[`SDC_HI_GRAN] ? 12'hfff : desc_lo_q[11:0]))
        else $error("base or limit mapping wrong");

    opsize_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && cs_load
        |=> op32_q == ($past(desc_hi_q[`SDC_HI_DSIZE]) ^ $past(ctrl_q[6])))
        else $error("operand size not taken from code size bit");

    // Field mapping seen from the raw descriptor words
    limit_map_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        limit == (desc_hi_q[`SDC_HI_GRAN] ? {desc_hi_q[19:16], desc_lo_q[15:0], `SDC_GRAN_FILL}
                                          : {12'h000, desc_hi_q[19:16], desc_lo_q[15:0]}))
        else $error("limit not built from the limit field");

    field_map_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        descriptor_privilege_level == desc_hi_q[`SDC_HI_DPL_MSB:`SDC_HI_DPL_LSB]
        && present == desc_hi_q[`SDC_HI_PRESENT])
        else $error("privilege level or present flag mapping wrong");

    code_class_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        user == desc_hi_q[`SDC_HI_USER] && is_code == (user && desc_hi_q[`SDC_HI_TYPE_MSB]))
        else $error("code or data class decoded wrong");

    dsize_sys_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !user |-> !dsize)
        else $error("system descriptor given a size bit");

    // Outcome checks on the evaluation cycle, with the accessed bit hold check
    absent_ok_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && !present |=> !ok_q && cpl_q == $past(cpl_q))
        else $error("absent descriptor accepted");

    sys_data_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && (is_rd || is_wr) && !user |=> gp_q)
        else $error("data access to system descriptor accepted");

    range_ok_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_rd && is_data && !expdown
        && last_byte <= {1'b0, limit} |=> !gp_q)
        else $error("read inside limit faulted");

    read_ok_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_rd && is_code && seg_type[`SDC_TY_READ]
        && !lim_fault |=> !gp_q)
        else $error("read of readable code faulted");

    conform_ok_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_xfer && is_code && conform |=> !gp_q && ok_q)
        else $error("conforming transfer refused");

    gate_level_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && present && is_xfer && is_code && !conform && via_gate
        |=> cpl_q == $past(descriptor_privilege_level))
        else $error("gated transfer did not take target level");

    acc_only_load_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        !wr_hi && !(state_q == SDC_ST_EVAL && cs_load)
        |=> $stable(desc_hi_q[`SDC_HI_ACCESSED]))
        else $error("accessed bit changed without load or write");

    size_hold_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && !cs_load |=> $stable(op32_q) && $stable(ad32_q))
        else $error("default sizes changed without code load");

    addrsize_a: assert property (@(posedge i_clk) disable iff (!i_resetn)
        state_q == SDC_ST_EVAL && cs_load
        |=> ad32_q == ($past(desc_hi_q[`SDC_HI_DSIZE]) ^ $past(ctrl_q[`SDC_CTRL_ADOVR])))
        else $error("address size not taken from code size bit");
endmodule // sdc_checker
`default_nettype wire

// ==== bench/sdc_pipe_model.sv ====
`timescale 1ns/1ps
`default_nettype none

module sdc_pipe_model (
    input  wire logic        i_clk,
    output logic             o_psel,
    output logic             o_penable,
    output logic             o_pwrite,
    output logic      [7:0]  o_paddr,
    output logic      [31:0] o_pwdata,
    input  wire logic [31:0] i_prdata,
    input  wire logic        i_pready,
    input  wire logic        i_pslverr,
    output logic             o_timeout
);
    // Bus idle at time zero
    initial begin
        o_psel    = 1'h0;
        o_penable = 1'h0;
        o_pwrite  = 1'h0;
        o_paddr   = 8'h00;
        o_pwdata  = 32'h0;
        o_timeout = 1'h0;
    end

    // One transfer; released lines are scrambled so stale values never match
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q, output logic e);
        int n;
        o_psel   <= 1'h1;
        o_pwrite <= w;
        o_paddr  <= a;
        o_pwdata <= d;
        @(posedge i_clk);
        o_penable <= 1'h1;
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (i_pready !== 1'h1 && n < 50);
        o_timeout = (i_pready !== 1'h1);
        q = i_prdata;
        e = i_pslverr;
        o_psel    <= 1'h0;
        o_penable <= 1'h0;
        o_paddr   <= ~a;
        o_pwdata  <= ~d;
        @(posedge i_clk);
    endtask
endmodule // sdc_pipe_model

`default_nettype wire

// ==== bench/sdc_checker_test.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "sdc_defines.svh"

module sdc_checker_test;
    import sdc_pkg::*;
    logic        clk, resetn, psel, penable, pwrite, pready, pslverr;
    logic        prot_f, absent_f, done, tmo;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic [1:0]  cur_lvl;
    int          mismatches = 0;
    int          n_checks = 0;

    sdc_checker uut (.i_clk(clk), .i_resetn(resetn), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .o_general_protection_fault(prot_f),
        .o_segment_absent_fault(absent_f), .o_done(done),
        .o_current_privilege_level(cur_lvl));

    sdc_pipe_model pm (.i_clk(clk), .o_psel(psel), .o_penable(penable), .o_pwrite(pwrite),
        .o_paddr(paddr), .o_pwdata(pwdata), .i_prdata(prdata), .i_pready(pready),
        .i_pslverr(pslverr), .o_timeout(tmo));

    // Free-running clock
    initial begin
        clk = 1'h0;
        forever #4 clk = ~clk;
    end

    task automatic test_done();
        if (mismatches == 0 && n_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic hang();
        chk("timeout", 32'h0, 32'h1);
        test_done();
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Register access wrappers
    task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
        pm.xfer(1'h0, a, 32'h0, q, e);
        if (tmo === 1'h1) hang();
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        pm.xfer(1'h1, a, d, q, e);
        if (tmo === 1'h1) hang();
    endtask

    task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        logic        e;
        rd(a, q, e);
        chk(nm, exp, q);
    endtask

    function automatic logic [31:0] hd(input logic [3:0] f, lm, ps, ty);
        return {8'h00, f, lm, ps, ty, 8'h00};
    endfunction

    function automatic logic [7:0] ctl(input logic [1:0] op, input logic [2:0] m1,
                                       input logic gt, input logic [1:0] pf);
        return {pf, gt, m1, op};
    endfunction

    // Full check: load descriptor, start, wait for done, compare faults
    task automatic run(input logic [31:0] lo, hi, off, input logic [7:0] c,
                       input logic g, a);
        int n;
        wr(`SDC_OFF_DESC_LO, lo);
        wr(`SDC_OFF_DESC_HI, hi);
        wr(`SDC_OFF_OFFSET, off);
        wr(`SDC_OFF_CTRL, {24'h0, c});
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'h1 && n < 8);
        if (done !== 1'h1) hang();
        chk("prot", {31'h0, g}, {31'h0, prot_f});
        chk("absent", {31'h0, a}, {31'h0, absent_f});
        @(posedge clk);
    endtask

    task automatic t_reset();
        logic [31:0] q;
        logic        e;
        chk("lvl", 32'h0, {30'h0, cur_lvl});
        rdc("status", `SDC_OFF_STATUS, 32'h0);
        rd(8'h20, q, e);
        chk("unmapped", 32'h1, {31'h0, e});
        wr(`SDC_OFF_BASE, 32'h1234);
        rdc("base ro", `SDC_OFF_BASE, 32'h0);
        chk("ready", 32'h1, {31'h0, pready});
        run(32'hffff, hd(0, 0, 4'h9, 4'ha), 0, ctl(2, 0, 0, 0), 0, 0);
    endtask

    // Byte limit, partial overrun, base assembly, spare bit
    task automatic t_limits();
        logic [31:0] o4 [4] = '{32'h31231, 32'h31232, 32'h31234, 32'h31235};
        for (int i = 0; i < 4; i++)
            run(32'h56781234, 32'hab53d2cd, o4[i], ctl(SDC_OP_READ, i < 2 ? 3'h3 : 3'h0,
                1'h0, 2'h0), i[0], 1'h0);
        rdc("base", `SDC_OFF_BASE, 32'habcd1234);
        rdc("limit", `SDC_OFF_LIMIT, 32'h00031234);
        rdc("hi kept", `SDC_OFF_DESC_HI, 32'hab53d2cd);
    endtask

    task automatic t_gran();
        run(32'h0, hd(4'h8, 4'h0, 4'h9, 4'h2), 32'hffe, ctl(0, 3'h1, 0, 0), 0, 0);
        run(32'h0, hd(4'h8, 4'h0, 4'h9, 4'h2), 32'hfff, ctl(0, 3'h1, 0, 0), 1, 0);
        rdc("limit", `SDC_OFF_LIMIT, 32'hfff);
        run(32'h1, hd(4'h8, 4'h0, 4'h9, 4'h2), 32'h1fff, ctl(0, 3'h0, 0, 0), 0, 0);
        rdc("limit", `SDC_OFF_LIMIT, 32'h1fff);
        run(32'h0, hd(4'h0, 4'h0, 4'h9, 4'h2), 32'h0, ctl(0, 3'h0, 0, 0), 0, 0);
        run(32'h0, hd(4'h0, 4'h0, 4'h9, 4'h2), 32'h1, ctl(0, 3'h0, 0, 0), 1, 0);
    endtask

    task automatic t_absent();
        run(32'hffff, hd(4'h0, 4'h0, 4'h1, 4'h2), 32'h0, ctl(0, 3'h0, 0, 0), 0, 1);
        run(32'hffff, hd(4'h0, 4'h0, 4'h1, 4'ha), 32'h0, ctl(2, 3'h0, 0, 0), 0, 1);
        rdc("hi kept", `SDC_OFF_DESC_HI, hd(4'h0, 4'h0, 4'h1, 4'ha));
    endtask

    // Every code type: read, write, load into code register
    task automatic t_code();
        for (int t = 8; t < 16; t++) begin
            run(32'hffff, hd(0, 0, 4'h9, t[3:0]), 0, ctl(0, 0, 0, 0), ~t[1], 0);
            run(32'hffff, hd(0, 0, 4'h9, t[3:0]), 0, ctl(1, 0, 0, 0), 1, 0);
            run(32'hffff, hd(0, 0, 4'h9, t[3:0]), 0, ctl(2, 0, 0, 0), 0, 0);
            rdc("accessed", `SDC_OFF_DESC_HI, hd(0, 0, 4'h9, t[3:0] | 4'h1));
        end
    endtask

    // System, write-protect and expand-down data cases
    task automatic t_data();
        logic [31:0] of [6] = '{32'hff, 32'h100, 32'hffff, 32'hfffe, 32'hffff, 32'h10000};
        run(32'hffff, hd(0, 0, 4'h8, 4'h2), 0, ctl(0, 0, 0, 0), 1, 0);
        run(32'hffff, hd(0, 0, 4'h9, 4'h0), 0, ctl(1, 0, 0, 0), 1, 0);
        run(32'hffff, hd(0, 0, 4'h9, 4'h2), 0, ctl(1, 0, 0, 0), 0, 0);
        for (int i = 0; i < 6; i++)
            run(32'hff, hd(i == 5 ? 4'h4 : 4'h0, 0, 4'h9, 4'h6), of[i],
                ctl(0, i == 3 || i == 4, 0, 0), i == 0 || i == 4, 0);
    endtask

    // Privilege on transfers and default sizes on code load
    task automatic t_xfer();
        wr(`SDC_OFF_CPL, 32'h3);
        run(32'hffff, hd(0, 0, 4'h9, 4'he), 0, ctl(3, 0, 0, 0), 0, 0);
        chk("lvl", 32'h3, {30'h0, cur_lvl});
        run(32'hffff, hd(0, 0, 4'hd, 4'ha), 0, ctl(3, 0, 0, 0), 1, 0);
        run(32'hffff, hd(0, 0, 4'hd, 4'ha), 0, ctl(3, 0, 1, 0), 0, 0);
        chk("lvl", 32'h2, {30'h0, cur_lvl});
        run(32'hffff, hd(4'h4, 0, 4'hd, 4'ha), 0, ctl(2, 0, 0, 2'h0), 0, 0);
        rdc("sizes", `SDC_OFF_STATUS, 32'he8);
        run(32'hffff, hd(4'h4, 0, 4'hd, 4'ha), 0, ctl(2, 0, 0, 2'h1), 0, 0);
        rdc("sizes", `SDC_OFF_STATUS, 32'ha8);
        run(32'hffff, hd(4'h0, 0, 4'hd, 4'ha), 0, ctl(2, 0, 0, 2'h3), 0, 0);
        rdc("sizes", `SDC_OFF_STATUS, 32'he8);
    endtask

    // Main sequence
    initial begin
        resetn = 1'h0;
        repeat (2) @(posedge clk);
        resetn <= 1'h1;
        @(posedge clk);
        t_reset();
        t_limits();
        t_gran();
        t_absent();
        t_code();
        t_data();
        t_xfer();
        test_done();
    end
endmodule // sdc_checker_test

`default_nettype wire
